// file: src/ldw_dev.sv
`timescale 1ns/10ps
`include "ldw_map.svh"
// Operation
// - Mode high with strobe low loads control.
// - Control word holds four instruction bits.
// - Data strobes fill next sequential digit.
// - After eight digits, strobes ignored until control.
// - Host rewrites all digits to change one.
// - Random-access control from tri-level pin only.
// - Address plus low strobe stores data there.
// - Addressed write changes only that digit.
// - Mode low during strobe means display data.
// - Lamps: host sends raw, data-follows control first.
// - Raw mode drives outputs from stored bits.
// - Control bits 4..7: shutdown, decode, font, follows.
// - Pin: high hex, float alternate, low shutdown.
// - Shutdown still accepts memory writes.
// - Sequential outputs blank while data written.
module ldw_dev
    import ldw_pkg::*;
(
    input  wire logic       clock_i,      // Clock, 200 MHz.
    input  wire logic       resetn_i,     // Async reset, active low.
    input  wire logic       random_i,     // High: random-access variant.
    input  wire logic [2:0] rd_digit_i,   // Digit to read out.
    output logic [7:0]      rd_byte_o,    // Byte of that digit, decoded unless raw mode.
    output logic            raw_o,        // Raw segment mode.
    output logic            hexa_o,       // Hex font, else alternate.
    output logic            shutdown_o,   // Display sections off.
    output logic            blank_o,      // Display blanked.
    output logic            seq_full_o,   // Not armed: from reset, after a non-follows word, or all eight written.
    output logic [2:0]      seq_ptr_o,    // Next sequential digit.
    ldw_if.dev              bus           // Display write bus.
);
    // ----------------------------------------------------------------
    // Storage and synchroniser stages
    // ----------------------------------------------------------------
    // Pins come from outside and pass two flip-flops first.
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic [2:0] adr_s1;
    logic [2:0] adr_s2;
    logic       mod_s1;
    logic       mod_s2;
    logic       wrn_s1;
    logic       wrn_s2;
    logic       wrn_s3;
    logic [1:0] tri_s1;
    logic [1:0] tri_s2;
    logic [7:0] mem_q [`LDW_DIGITS];
    logic [7:0] cw_q;
    logic [2:0] ptr_q;
    logic       armed_q;
    logic       fall;
    logic       rd_raw;

    // Decoded formats keep the point bit and the four code bits only.
    function automatic logic [7:0] decoded_byte(input logic [7:0] b);
        return {b[7], 3'h0, b[3:0]};
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two-stage synchronisers; the third write stage feeds edge detection.
    // Only the second and third stages are read by logic, so a metastable
    // first stage never reaches the write decode. The write stages reset
    // high, the idle strobe level, so no false edge follows reset.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dat_s1 <= 8'h00;
            dat_s2 <= 8'h00;
            adr_s1 <= 3'h0;
            adr_s2 <= 3'h0;
            mod_s1 <= 1'b0;
            mod_s2 <= 1'b0;
            wrn_s1 <= 1'b1;
            wrn_s2 <= 1'b1;
            wrn_s3 <= 1'b1;
            tri_s1 <= LDW_TRI_HIGH;
            tri_s2 <= LDW_TRI_HIGH;
        end else begin
            dat_s1 <= bus.input_bus_bits;
            dat_s2 <= dat_s1;
            adr_s1 <= bus.digit_select_lines;
            adr_s2 <= adr_s1;
            mod_s1 <= bus.mode;
            mod_s2 <= mod_s1;
            wrn_s1 <= bus.write_n;
            wrn_s2 <= wrn_s1;
            wrn_s3 <= wrn_s2;
            tri_s1 <= bus.tri_level_control_pin;
            tri_s2 <= tri_s1;
        end
    end

    // ----------------------------------------------------------------
    // Strobe edge detection
    // ----------------------------------------------------------------
    // One write per falling strobe edge; a long low phase writes only once.
    assign fall = wrn_s3 && !wrn_s2;

    // ----------------------------------------------------------------
    // Sequential control word and pointer
    // ----------------------------------------------------------------
    // Control word register for the sequential variant; only the four
    // instruction bits are kept, the low nibble is a don't care.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cw_q <= `LDW_CW_RESET;
        end else if (!random_i && fall && mod_s2) begin
            cw_q <= {dat_s2[7:4], 4'h0};
        end
    end

    // Sequential pointer; every control word rewinds it to the first digit.
    // It wraps after the last digit, but by then arming has dropped, so the
    // wrapped value never addresses a write.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ptr_q <= 3'h0;
        end else if (!random_i && fall) begin
            if (mod_s2) begin
                ptr_q <= 3'h0;
            end else if (armed_q) begin
                ptr_q <= ptr_q + 3'h1;
            end
        end
    end

    // Arming; a full pass of eight digits disarms further data strobes.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            armed_q <= 1'b0;
        end else if (!random_i && fall) begin
            if (mod_s2) begin
                armed_q <= dat_s2[`LDW_CW_DATA_FOLLOWS];
            end else if (armed_q && (ptr_q == `LDW_PTR_LAST)) begin
                armed_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Display memory
    // ----------------------------------------------------------------
    // Display memory; writes are taken in shutdown too, since only the
    // output sections are switched off there.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < `LDW_DIGITS; i++) begin
                mem_q[i] <= `LDW_MEM_RESET;
            end
        end else if (fall) begin
            if (random_i) begin
                mem_q[adr_s2] <= dat_s2;
            end else if (!mod_s2 && armed_q) begin
                mem_q[ptr_q] <= dat_s2;
            end
        end
    end

    // ----------------------------------------------------------------
    // Readout and display modes
    // ----------------------------------------------------------------
    // Raw mode is only reachable in the sequential variant; the random
    // variant always decodes.
    assign rd_raw = !random_i && cw_q[`LDW_CW_RAW];

    // Readout; raw mode passes stored bits straight to the segments.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_byte_o <= 8'h00;
        end else begin
            rd_byte_o <= rd_raw ? mem_q[rd_digit_i]
                                : decoded_byte(mem_q[rd_digit_i]);
        end
    end

    // Mode outputs from the control word or the three-level pin. The pin
    // acts at once and never waits for a strobe; a low level blanks the
    // display and sets shutdown, while readout keeps decoding and memory keeps taking writes.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            raw_o      <= 1'b0;
            hexa_o     <= 1'b1;
            shutdown_o <= 1'b0;
            blank_o    <= 1'b0;
        end else if (random_i) begin
            raw_o      <= 1'b0;
            hexa_o     <= (tri_s2 == LDW_TRI_HIGH);
            shutdown_o <= (tri_s2 == LDW_TRI_LOW);
            blank_o    <= (tri_s2 == LDW_TRI_LOW);
        end else begin
            raw_o      <= cw_q[`LDW_CW_RAW];
            hexa_o     <= cw_q[`LDW_CW_HEXA];
            shutdown_o <= !cw_q[`LDW_CW_SHUTDOWN_N];
            blank_o    <= !cw_q[`LDW_CW_SHUTDOWN_N] || (armed_q && !mod_s2);
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    // Full reads high from reset until a data-follows control word comes,
    // and again once the eighth digit of a pass has been stored.
    assign seq_full_o = !armed_q;
    assign seq_ptr_o  = ptr_q;
endmodule // ldw_dev

// file: src/ldw_fifo.sv
`timescale 1ns/10ps
// Flip-flop FIFO with valid/ready on both sides.
module ldw_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input  wire logic             clock_i,  // Clock.
    input  wire logic             resetn_i, // Async reset, active low.
    input  wire logic [WIDTH-1:0] wdata_i,  // Write data.
    input  wire logic             wvalid_i, // Write valid.
    output logic                  wready_o, // Not full.
    output logic      [WIDTH-1:0] rdata_o,  // Head data.
    output logic                  rvalid_o, // Not empty.
    input  wire logic             rready_i  // Read accept.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Handshake terms.
    assign wready_o = (cnt_q != DEPTH[AW:0]);
    assign rvalid_o = (cnt_q != '0);
    assign push     = wvalid_i && wready_o;
    assign pop      = rvalid_o && rready_i;
    assign rdata_o  = mem_q[rp_q];

    // Storage is written without reset.
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wp_q] <= wdata_i;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // ldw_fifo

// file: src/ldw_host.sv
`timescale 1ns/10ps
`include "ldw_map.svh"
// Host end: queues writes in a FIFO and plays each as one strobe cycle.
module ldw_host
    import ldw_pkg::*;
(
    input  wire logic       clock_i,     // Clock, 200 MHz.
    input  wire logic       resetn_i,    // Async reset, active low.
    input  wire logic [7:0] wr_data_i,   // Byte to write.
    input  wire logic [2:0] wr_addr_i,   // Digit address (random access).
    input  wire logic       wr_ctrl_i,   // High: control word.
    input  wire logic       wr_valid_i,  // Write request.
    output logic            wr_ready_o,  // Queue has room.
    input  wire logic [1:0] tri_level_i, // Level for the control pin.
    output logic            busy_o,      // Strobe cycle in progress.
    ldw_if.host             bus          // Display write bus.
);
    ldw_hstate_e st_q;
    logic [3:0]  cnt_q;
    logic [11:0] fdata;
    logic        fvalid;
    logic        take;
    logic [7:0]  dat_q;
    logic [2:0]  adr_q;
    logic        mod_q;
    logic        wrn_q;
    logic [1:0]  tri_q;

    // Command queue; the strobe machine drains it one entry per cycle set.
    ldw_fifo #(.WIDTH(12), .DEPTH(16)) u_fifo (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .wdata_i  ({wr_ctrl_i, wr_addr_i, wr_data_i}),
        .wvalid_i (wr_valid_i),
        .wready_o (wr_ready_o),
        .rdata_o  (fdata),
        .rvalid_o (fvalid),
        .rready_i (take)
    );

    assign take   = (st_q == LDW_H_IDLE) && fvalid;
    assign busy_o = (st_q != LDW_H_IDLE);

    // Strobe sequencer: setup, low phase, high phase.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q  <= LDW_H_IDLE;
            cnt_q <= 4'h0;
            wrn_q <= 1'b1;
        end else begin
            case (st_q)
                LDW_H_IDLE: begin
                    if (fvalid) begin
                        st_q <= LDW_H_SETUP;
                    end
                end
                LDW_H_SETUP: begin
                    st_q  <= LDW_H_LOW;
                    wrn_q <= 1'b0;
                    cnt_q <= `LDW_STROBE_LOW_CYC;
                end
                LDW_H_LOW: begin
                    if (cnt_q == 4'h1) begin
                        st_q  <= LDW_H_HIGH;
                        wrn_q <= 1'b1;
                        cnt_q <= `LDW_STROBE_HIGH_CYC;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                LDW_H_HIGH: begin
                    if (cnt_q == 4'h1) begin
                        st_q <= LDW_H_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: begin
                    st_q <= LDW_H_IDLE;
                end
            endcase
        end
    end

    // Bus fields are held stable over the whole strobe cycle.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dat_q <= 8'h00;
            adr_q <= 3'h0;
            mod_q <= 1'b0;
        end else if (take) begin
            dat_q <= fdata[7:0];
            adr_q <= fdata[10:8];
            mod_q <= fdata[11];
        end
    end

    // Control pin level follows the user input.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tri_q <= LDW_TRI_HIGH;
        end else begin
            tri_q <= tri_level_i;
        end
    end

    assign bus.input_bus_bits        = dat_q;
    assign bus.digit_select_lines    = adr_q;
    assign bus.mode                  = mod_q;
    assign bus.write_n               = wrn_q;
    assign bus.tri_level_control_pin = tri_q;
endmodule // ldw_host

// file: src/ldw_if.sv
`timescale 1ns/10ps
// Parallel write bus between host and display driver.
interface ldw_if;
    logic [7:0] input_bus_bits;       // Data/control byte.
    logic [2:0] digit_select_lines;   // Random-access digit address.
    logic       write_n;              // Active-low write strobe.
    logic       mode;                 // High: control word (sequential).
    logic [1:0] tri_level_control_pin;// Decoded three-level control.
    modport host (output input_bus_bits, digit_select_lines, write_n, mode,
                  tri_level_control_pin);
    modport dev  (input input_bus_bits, digit_select_lines, write_n, mode,
                  tri_level_control_pin);
endinterface

// file: src/ldw_map.svh
`ifndef LDW_MAP_SVH
`define LDW_MAP_SVH
// Control word field positions.
`define LDW_CW_SHUTDOWN_N   4
`define LDW_CW_RAW          5
`define LDW_CW_HEXA         6
`define LDW_CW_DATA_FOLLOWS 7
// Memory geometry.
`define LDW_DIGITS          8
`define LDW_PTR_LAST        3'h7
// Reset values.
`define LDW_CW_RESET        8'h10
`define LDW_MEM_RESET       8'h00
// Host strobe timing in clock cycles (low phase and high phase).
`define LDW_STROBE_LOW_CYC  4'h4
`define LDW_STROBE_HIGH_CYC 4'h4
`endif

// file: src/ldw_pkg.sv
package ldw_pkg;
    typedef logic [7:0] ldw_byte_t;
    typedef logic [2:0] ldw_addr_t;
    // Three-level control pin as decoded levels.
    typedef enum logic [1:0] {
        LDW_TRI_LOW   = 2'h0,
        LDW_TRI_FLOAT = 2'h1,
        LDW_TRI_HIGH  = 2'h3
    } ldw_tri_e;
    // Host sequencer states, Gray along the usual path.
    typedef enum logic [1:0] {
        LDW_H_IDLE  = 2'h0,
        LDW_H_SETUP = 2'h1,
        LDW_H_LOW   = 2'h3,
        LDW_H_HIGH  = 2'h2
    } ldw_hstate_e;
endpackage

// file: verif/ldw_assertions.sv
`timescale 1ns/10ps
// Watches the parallel write bus between the host end and the display end.
module ldw_assertions (
    input wire logic       clock_i,               // Clock.
    input wire logic       resetn_i,              // Async reset, active low.
    input wire logic [7:0] input_bus_bits,        // Data/control byte.
    input wire logic [2:0] digit_select_lines,    // Digit address.
    input wire logic       write_n,               // Active-low write strobe.
    input wire logic       mode,                  // High: control word.
    input wire logic [1:0] tri_level_control_pin  // Decoded three-level control.
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // ----------------------------------------------------------------
    // Strobe shape
    // ----------------------------------------------------------------
    // The four low samples from the falling edge on, then release.
    sequence s_low_rest;
        !write_n [*4] ##1 write_n;
    endsequence
    // The high phase that separates two strobes.
    sequence s_high_gap;
        write_n [*4];
    endsequence
    property p_low_len;
        $fell(write_n) |-> s_low_rest;
    endproperty
    a_low_len: assert property (p_low_len) else $error("strobe low phase length");
    property p_high_len;
        $rose(write_n) |-> s_high_gap;
    endproperty
    a_high_len: assert property (p_high_len) else $error("strobe high gap length");
    // ----------------------------------------------------------------
    // Qualifiers held around the strobe; legal pin levels
    // ----------------------------------------------------------------
    property p_data_hold;
        !write_n && !$past(write_n) |-> $stable(input_bus_bits);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved in strobe");
    property p_mode_hold;
        !write_n && !$past(write_n) |-> $stable(mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved in strobe");
    property p_addr_hold;
        !write_n && !$past(write_n) |-> $stable(digit_select_lines);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
    property p_setup;
        $fell(write_n) |-> $stable(input_bus_bits) && $stable(mode) && $stable(digit_select_lines);
    endproperty
    a_setup: assert property (p_setup) else $error("fields not set up before strobe");
    property p_addr_change;
        $changed(digit_select_lines) |-> write_n;
    endproperty
    a_addr_change: assert property (p_addr_change) else $error("address changed while low");
    property p_tri_legal;
        tri_level_control_pin != 2'h2;
    endproperty
    a_tri_legal: assert property (p_tri_legal) else $error("illegal pin level code");
endmodule // ldw_assertions

// file: verif/test_led_display_write_port.sv
`timescale 1ns/10ps
// Host and both display variants on one bus, checked against a queue-free model.
module test_led_display_write_port
    import ldw_pkg::*;
;
    logic       clock_i = 1'b0;
    logic       resetn_i = 1'b0;
    ldw_byte_t  wr_data = 8'h00;
    ldw_addr_t  wr_addr = 3'h0;
    logic       wr_ctrl = 1'b0;
    logic       wr_valid = 1'b0;
    logic [1:0] tri_lvl = 2'h3;
    ldw_addr_t  rd_dig = 3'h0;
    logic       wr_ready, busy, s_raw, s_hexa, s_shut, s_blank, s_full, r_raw, r_hexa, r_shut;
    logic       r_blank;
    ldw_byte_t  s_byte, r_byte;
    ldw_addr_t  s_ptr;
    ldw_byte_t  smem [8];
    ldw_byte_t  rmem [8];
    logic [3:0] cw = 4'h1;
    logic       armed = 1'b0;
    logic       lastc = 1'b0;
    int         ptr = 0;
    int         mismatches = 0;
    int         n_compared = 0;
    int         seed = 66094;
    int         full_seen = 0;
    int         r, k;
    ldw_byte_t  cwt [4] = '{8'h90, 8'hb0, 8'he0, 8'h00};
    logic [1:0] tl [3] = '{2'h0, 2'h1, 2'h3};
    // Clock of 5 ns period.
    always #2.5 clock_i = ~clock_i;
    ldw_if bus_if ();
    ldw_host ldw_host_inst (.clock_i(clock_i), .resetn_i(resetn_i), .wr_data_i(wr_data),
        .wr_addr_i(wr_addr), .wr_ctrl_i(wr_ctrl), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready),
        .tri_level_i(tri_lvl), .busy_o(busy), .bus(bus_if));
    ldw_dev ldw_dev_inst (.clock_i(clock_i), .resetn_i(resetn_i), .random_i(1'b0),
        .rd_digit_i(rd_dig), .rd_byte_o(s_byte), .raw_o(s_raw), .hexa_o(s_hexa),
        .shutdown_o(s_shut), .blank_o(s_blank), .seq_full_o(s_full), .seq_ptr_o(s_ptr),
        .bus(bus_if));
    ldw_dev ldw_dev_inst_ra (.clock_i(clock_i), .resetn_i(resetn_i), .random_i(1'b1),
        .rd_digit_i(rd_dig), .rd_byte_o(r_byte), .raw_o(r_raw), .hexa_o(r_hexa),
        .shutdown_o(r_shut), .blank_o(r_blank), .seq_full_o(), .seq_ptr_o(), .bus(bus_if));
    ldw_assertions ldw_assertions_inst (.clock_i(clock_i), .resetn_i(resetn_i),
        .input_bus_bits(bus_if.input_bus_bits), .digit_select_lines(bus_if.digit_select_lines),
        .write_n(bus_if.write_n), .mode(bus_if.mode),
        .tri_level_control_pin(bus_if.tri_level_control_pin));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Decoded formats keep the point bit and the four code bits.
    function automatic ldw_byte_t dec(input ldw_byte_t b);
        return {b[7], 3'h0, b[3:0]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Queues one write and steps the model as both variants would.
    task automatic send(input logic c, input ldw_byte_t d, input ldw_addr_t a);
        wr_ctrl = c;
        wr_data = d;
        wr_addr = a;
        wr_valid = 1'b1;
        while (wr_ready !== 1'b1) begin
            full_seen = 1;
            @(posedge clock_i);
            #1;
        end
        @(posedge clock_i);
        #1;
        lastc = c;
        rmem[a] = d;
        if (c) begin
            cw = d[7:4];
            armed = d[7];
            if (d[7]) ptr = 0;
        end else if (armed) begin
            smem[ptr] = d;
            if (ptr == 7) armed = 1'b0;
            else ptr++;
        end
    endtask
    // Waits until the bus has been quiet for twelve cycles.
    task automatic drain();
        int q;
        int n;
        wr_valid = 1'b0;
        q = 0;
        for (n = 0; n < 4000 && q < 12; n++) begin
            @(posedge clock_i);
            #1;
            q = (busy === 1'b0) ? q + 1 : 0;
        end
        // A bus that never goes quiet counts as a mismatch.
        if (q < 12) mismatches++;
    endtask
    task automatic check_all(input string t);
        int i;
        for (i = 0; i < 8; i++) begin
            rd_dig = 3'(i);
            repeat (2) @(posedge clock_i);
            #1;
            chk("seq_byte", cw[1] ? smem[i] : dec(smem[i]), s_byte);
            chk("ra_byte", dec(rmem[i]), r_byte);
        end
        chk("raw", {7'h0, cw[1]}, {7'h0, s_raw});
        chk("hexa", {7'h0, cw[2]}, {7'h0, s_hexa});
        chk("shutdown", {7'h0, !cw[0]}, {7'h0, s_shut});
        chk("full", {7'h0, !armed}, {7'h0, s_full});
        chk("blank", {7'h0, !cw[0] || (armed && !lastc)}, {7'h0, s_blank});
        if (armed) chk("ptr", 8'(ptr), {5'h0, s_ptr});
        chk("ra_shut", {7'h0, tri_lvl == 2'h0}, {7'h0, r_shut});
        chk("ra_blank", {7'h0, tri_lvl == 2'h0}, {7'h0, r_blank});
        if (tri_lvl != 2'h0) chk("ra_hexa", {7'h0, tri_lvl == 2'h3}, {7'h0, r_hexa});
        chk("ra_raw", 8'h00, {7'h0, r_raw});
        chk("ready", 8'h01, {7'h0, wr_ready});
        chk("busy", 8'h00, {7'h0, busy});
        $display("test %s done", t);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        for (k = 0; k < 8; k++) begin
            smem[k] = 8'h00;
            rmem[k] = 8'h00;
        end
        repeat (12) @(posedge clock_i);
        #1 resetn_i = 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        check_all("reset");
        // Every control bit value, extra strobes past eight, all pin levels.
        for (r = 0; r < 4; r++) begin
            tri_lvl = tl[r % 3];
            send(1'b1, cwt[r] | (8'($random(seed)) & 8'h0f), 3'($random(seed)));
            for (k = 0; k < 10; k++) send(1'b0, 8'($random(seed)), 3'($random(seed)));
            drain();
            check_all("round");
        end
        // Part-filled sequence, then a burst that fills the queue.
        send(1'b1, 8'h90, 3'h0);
        for (k = 0; k < 3; k++) send(1'b0, 8'($random(seed)), 3'($random(seed)));
        drain();
        check_all("partial");
        for (k = 0; k < 20; k++) send(1'b0, 8'($random(seed)), 3'($random(seed)));
        drain();
        check_all("burst");
        chk("full_seen", 8'h01, 8'(full_seen));
        finish_test();
    end
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
endmodule // test_led_display_write_port
